// ### core/nac_defines.svh
// Register map, field positions, keys and timing counts of the NVM access controller.
// Assumes inclusion by bare name from package and modules.
`ifndef NAC_DEFINES_SVH
`define NAC_DEFINES_SVH

// Word offsets on the Wishbone bus (byte addresses)
`define NAC_OFS_CTRL 8'h00
`define NAC_OFS_UNLOCK 8'h04
`define NAC_OFS_ADDR 8'h08
`define NAC_OFS_DATA 8'h0C
`define NAC_OFS_FLAGS 8'h10
`define NAC_OFS_ENABLES 8'h14
`define NAC_OFS_PRIORITY 8'h18

// Control register bit positions
`define NAC_BIT_ARRAY_SEL 7
`define NAC_BIT_CFG_SEL 6
`define NAC_BIT_ROW_WIPE 4
`define NAC_BIT_ABORTED 3
`define NAC_BIT_PERMIT 2
`define NAC_BIT_PROG 1
`define NAC_BIT_FETCH 0

// Completion flag position in the peripheral flag, enable and priority registers
`define NAC_BIT_DONE 4

// Unlock keys
`define NAC_KEY_FIRST 8'h55
`define NAC_KEY_SECOND 8'hAA

// Self-timed program cycle and power-up hold, in core clock cycles
`define NAC_PROG_CYCLES 4000
`define NAC_PWRT_CYCLES 1000
`define NAC_CNT_W 16

`endif

// ### core/nac_pkg.sv
// Types shared by the NVM access controller modules.
// Assumes nac_defines.svh is on the include path.
package nac_pkg;
	`include "nac_defines.svh"

	// One-hot controller states
	typedef enum logic [2:0] {
		NAC_ST_IDLE = 3'b001,
		NAC_ST_READ = 3'b010,
		NAC_ST_PROG = 3'b100
	} nac_state_t;

	// Unlock sequence progress
	typedef enum logic [2:0] {
		NAC_UL_NONE = 3'b001,
		NAC_UL_FIRST = 3'b010,
		NAC_UL_ARMED = 3'b100
	} nac_unlock_t;

	// Target space picked by the select bits
	typedef enum logic [1:0] {
		NAC_TGT_EEPROM = 2'h0,
		NAC_TGT_FLASH = 2'h1,
		NAC_TGT_CONFIG = 2'h2
	} nac_target_t;

	// Space decode shared by fetch gating and the program cycle
	function automatic nac_target_t nac_target(input logic arr_sel, input logic cfg_sel);
		if (cfg_sel) begin
			return NAC_TGT_CONFIG;
		end else if (arr_sel) begin
			return NAC_TGT_FLASH;
		end
		return NAC_TGT_EEPROM;
	endfunction : nac_target
endpackage : nac_pkg

// ### core/nac_unlock_seq.sv
// Unlock sequence tracker: two key writes to the unlock port arm one program start.
// Assumes strobes are one-cycle pulses from the bus slave on the same clock.
`include "nac_defines.svh"
module nac_unlock_seq
	import nac_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Bus write strobes
	input wire logic unlock_wr_i,
	input wire logic other_wr_i,
	input wire logic [7:0] wdata_i,
	// Status
	output logic armed_o
);
	nac_unlock_t state_ff;
	nac_unlock_t nxt_state;

	// Any write that breaks the 55h, AAh order drops back to the start
	always_comb begin
		nxt_state = state_ff;
		if (unlock_wr_i) begin
			if (wdata_i == `NAC_KEY_FIRST) begin
				nxt_state = NAC_UL_FIRST;
			end else if (wdata_i == `NAC_KEY_SECOND && state_ff == NAC_UL_FIRST) begin
				nxt_state = NAC_UL_ARMED;
			end else begin
				nxt_state = NAC_UL_NONE;
			end
		end else if (other_wr_i) begin
			nxt_state = NAC_UL_NONE;
		end
	end

	// Sequence state
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_ff <= NAC_UL_NONE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	assign armed_o = (state_ff == NAC_UL_ARMED);
endmodule : nac_unlock_seq

// ### core/nac_eeprom_array.sv
// Data EEPROM array model: 256 bytes held in flip-flops, one write port.
// Assumes the controller writes at most one byte per cycle.
module nac_eeprom_array
	import nac_pkg::*;
(
	// Clock
	input wire logic clk_i,
	// Access port
	input wire logic we_i,
	input wire logic [7:0] addr_i,
	input wire logic [7:0] wdata_i,
	output logic [7:0] rdata_o
);
	logic [7:0] mem_ff [256];

	// Erase-before-write collapses to a single byte replace here
	always_ff @(posedge clk_i) begin
		if (we_i) begin
			mem_ff[addr_i] <= wdata_i;
		end
	end

	// Contents survive reset, as a nonvolatile store would
	assign rdata_o = mem_ff[addr_i];
endmodule : nac_eeprom_array

// ### core/nac_top.sv
// NVM access controller: Wishbone register file, one-cycle reads, self-timed writes.
// Assumes a classic Wishbone master on clk_i; por_i marks power-on, rst_i any reset.
// Behaviour
// - With config select clear, array select picks EEPROM (0) or flash (1).
// - Config select set sends later operations to configuration registers.
// - Writes need store permit; power-up clears store permit.
// - Aborted flag sets on program trigger, clears on normal completion.
// - Aborted flag stays set across reset mid-cycle or after improper attempt.
// - Aborted write leaves array and config select bits untouched.
// - Program trigger starts timed cycle; software sets only, hardware clears.
// - Completion sets done flag bit 4; only software clears it (here rst_i and por_i also clear it).
// - Fetch trigger does a one-cycle EEPROM read, then self-clears.
// - Fetch trigger ignored while array select or config select is one.
// - Row wipe makes next trigger erase flash row, then clears itself.
// - Unlock port stores nothing and reads as zero.
// - Address register is 8 bits, selecting 256 byte locations.
// - Data register holds the byte read or to be written.
// - Each EEPROM byte write erases then programs, timed on chip.
// - Control bit 5 is unimplemented and reads zero.
// - Row wipe, permit, program and fetch triggers reset to zero.
// - Write 55h then AAh to unlock port, then trigger; else refused.
// - Trigger refused unless permit already set; same-write setting fails.
// - During a cycle, control, address and data registers are frozen.
// - Writes blocked while the power-up timer runs.
//
// The placing of the registers and the Wishbone interface to the registers were left to the implementer.
`include "nac_defines.svh"
module nac_top
	import nac_pkg::*;
#(
	parameter logic [`NAC_CNT_W-1:0] PROG_CYCLES = `NAC_CNT_W'(`NAC_PROG_CYCLES),
	parameter logic [`NAC_CNT_W-1:0] PWRT_CYCLES = `NAC_CNT_W'(`NAC_PWRT_CYCLES)
)(
	// Clock and resets
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic por_i,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Status
	output logic prog_busy_o,
	output logic nvm_done_flag_o,
	output logic aborted_program_flag_o,
	output logic row_wipe_done_o
);
	// Bus and control state
	logic ack_ff;
	logic [31:0] rdat_ff;
	logic array_select_ff;
	logic config_space_select_ff;
	logic row_wipe_ff;
	logic aborted_ff;
	logic store_permit_ff;
	logic prog_trig_ff;
	logic fetch_trig_ff;
	logic [7:0] eeprom_address_ff;
	logic [7:0] eeprom_data_ff;
	logic done_flag_ff;
	logic done_enable_ff;
	logic done_priority_ff;
	logic [`NAC_CNT_W-1:0] prog_cnt_ff;
	logic [`NAC_CNT_W-1:0] pwrt_cnt_ff;
	logic busy_ff;
	logic wipe_pulse_ff;
	nac_state_t state_ff;
	nac_state_t nxt_state;

	// Decoded bus events
	logic bus_req;
	logic bus_wr;
	logic wr_ctrl;
	logic wr_unlock;
	logic wr_addr;
	logic wr_data;
	logic wr_flags;
	logic wr_enables;
	logic wr_priority;
	logic [7:0] wbyte;
	logic armed;
	logic pwrt_running;
	logic start_prog;
	logic bad_prog;
	logic start_fetch;
	logic prog_end;
	logic array_we;
	logic [7:0] array_rdata;
	logic [7:0] ctrl_view;
	logic [7:0] nxt_rdat;

	// A write lands at the edge where ack is seen, matching the master's sampling
	assign bus_req = wb_cyc_i & wb_stb_i;
	assign bus_wr = bus_req & wb_we_i & ack_ff & wb_sel_i[0];
	assign wbyte = wb_dat_i[7:0];
	assign wr_ctrl = bus_wr & (wb_adr_i == `NAC_OFS_CTRL);
	assign wr_unlock = bus_wr & (wb_adr_i == `NAC_OFS_UNLOCK);
	assign wr_addr = bus_wr & (wb_adr_i == `NAC_OFS_ADDR);
	assign wr_data = bus_wr & (wb_adr_i == `NAC_OFS_DATA);
	assign wr_flags = bus_wr & (wb_adr_i == `NAC_OFS_FLAGS);
	assign wr_enables = bus_wr & (wb_adr_i == `NAC_OFS_ENABLES);
	assign wr_priority = bus_wr & (wb_adr_i == `NAC_OFS_PRIORITY);

	// Program start needs unlock, prior permit, idle and power-up hold over
	assign pwrt_running = (pwrt_cnt_ff != '0);
	assign start_prog = wr_ctrl & wbyte[`NAC_BIT_PROG] & armed
		& store_permit_ff & ~busy_ff & ~pwrt_running;
	// A trigger written without the full handshake counts as improper
	assign bad_prog = wr_ctrl & wbyte[`NAC_BIT_PROG] & ~busy_ff & ~start_prog;
	// Fetch is gated by the select bits as they will stand after this write
	assign start_fetch = wr_ctrl & ~busy_ff & wbyte[`NAC_BIT_FETCH]
		& (nac_target(wbyte[`NAC_BIT_ARRAY_SEL], wbyte[`NAC_BIT_CFG_SEL])
		== NAC_TGT_EEPROM);
	assign prog_end = (state_ff == NAC_ST_PROG) && (prog_cnt_ff == '0);
	// Only the EEPROM target touches the byte array; other spaces just time out
	assign array_we = prog_end && (nac_target(array_select_ff, config_space_select_ff)
		== NAC_TGT_EEPROM);

	// Unlock sequence tracker
	nac_unlock_seq u_unlock (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.unlock_wr_i(wr_unlock),
		.other_wr_i(bus_wr & ~wr_unlock),
		.wdata_i(wbyte),
		.armed_o(armed)
	);

	// Byte array
	nac_eeprom_array u_array (
		.clk_i(clk_i),
		.we_i(array_we),
		.addr_i(eeprom_address_ff),
		.wdata_i(eeprom_data_ff),
		.rdata_o(array_rdata)
	);

	// Controller sequence
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			NAC_ST_IDLE: begin
				if (start_prog) begin
					nxt_state = NAC_ST_PROG;
				end else if (start_fetch) begin
					nxt_state = NAC_ST_READ;
				end
			end
			NAC_ST_READ: begin
				nxt_state = NAC_ST_IDLE;
			end
			NAC_ST_PROG: begin
				if (prog_cnt_ff == '0) begin
					nxt_state = NAC_ST_IDLE;
				end
			end
			default: begin
				nxt_state = NAC_ST_IDLE;
			end
		endcase
	end

	// State register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_ff <= NAC_ST_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// Self-timed cycle counter, loaded at start and run down to zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			prog_cnt_ff <= '0;
		end else if (start_prog) begin
			prog_cnt_ff <= PROG_CYCLES - `NAC_CNT_W'(1);
		end else if (state_ff == NAC_ST_PROG && prog_cnt_ff != '0) begin
			prog_cnt_ff <= prog_cnt_ff - `NAC_CNT_W'(1);
		end
	end

	// Busy follows the program cycle; a reset aborts it
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			busy_ff <= 1'b0;
		end else if (start_prog) begin
			busy_ff <= 1'b1;
		end else if (prog_end) begin
			busy_ff <= 1'b0;
		end
	end

	// Power-up hold counter restarts on every power-on reset
	always_ff @(posedge clk_i) begin
		if (por_i) begin
			pwrt_cnt_ff <= PWRT_CYCLES;
		end else if (pwrt_cnt_ff != '0) begin
			pwrt_cnt_ff <= pwrt_cnt_ff - `NAC_CNT_W'(1);
		end
	end

	// Select bits survive ordinary resets so a failed write can be traced
	always_ff @(posedge clk_i) begin
		if (por_i) begin
			array_select_ff <= 1'b0;
			config_space_select_ff <= 1'b0;
		end else if (wr_ctrl && !busy_ff) begin
			array_select_ff <= wbyte[`NAC_BIT_ARRAY_SEL];
			config_space_select_ff <= wbyte[`NAC_BIT_CFG_SEL];
		end
	end

	// Aborted flag: not touched by rst_i, so a reset mid-cycle leaves it set
	always_ff @(posedge clk_i) begin
		if (por_i) begin
			aborted_ff <= 1'b0;
		end else if (start_prog || bad_prog) begin
			aborted_ff <= 1'b1;
		end else if (prog_end) begin
			aborted_ff <= 1'b0;
		end else if (wr_ctrl && !busy_ff && !wbyte[`NAC_BIT_ABORTED]) begin
			aborted_ff <= 1'b0;
		end
	end

	// Row wipe and store permit are software fields, frozen while busy
	always_ff @(posedge clk_i) begin
		if (rst_i || por_i) begin
			row_wipe_ff <= 1'b0;
			store_permit_ff <= 1'b0;
		end else if (prog_end) begin
			row_wipe_ff <= 1'b0;
		end else if (wr_ctrl && !busy_ff) begin
			row_wipe_ff <= wbyte[`NAC_BIT_ROW_WIPE];
			store_permit_ff <= wbyte[`NAC_BIT_PERMIT];
		end
	end

	// Triggers: software can only set them, hardware clears at completion
	always_ff @(posedge clk_i) begin
		if (rst_i || por_i) begin
			prog_trig_ff <= 1'b0;
			fetch_trig_ff <= 1'b0;
		end else begin
			if (start_prog) begin
				prog_trig_ff <= 1'b1;
			end else if (prog_end) begin
				prog_trig_ff <= 1'b0;
			end
			fetch_trig_ff <= start_fetch;
		end
	end

	// Flash row erase completion pulse for the flash datapath
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wipe_pulse_ff <= 1'b0;
		end else begin
			wipe_pulse_ff <= prog_end && row_wipe_ff
				&& nac_target(array_select_ff, config_space_select_ff) == NAC_TGT_FLASH;
		end
	end

	// Address register, 8 bits wide, frozen during a cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			eeprom_address_ff <= 8'h00;
		end else if (wr_addr && !busy_ff) begin
			eeprom_address_ff <= wbyte;
		end
	end

	// Data register: loaded by software or by the one-cycle fetch
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			eeprom_data_ff <= 8'h00;
		end else if (state_ff == NAC_ST_READ) begin
			eeprom_data_ff <= array_rdata;
		end else if (wr_data && !busy_ff) begin
			eeprom_data_ff <= wbyte;
		end
	end

	// Done flag: completion wins over a software clear in the same cycle
	always_ff @(posedge clk_i) begin
		if (rst_i || por_i) begin
			done_flag_ff <= 1'b0;
		end else if (prog_end) begin
			done_flag_ff <= 1'b1;
		end else if (wr_flags) begin
			done_flag_ff <= wbyte[`NAC_BIT_DONE];
		end
	end

	// Enable and priority bits are storage only; this block raises no interrupt
	always_ff @(posedge clk_i) begin
		if (rst_i || por_i) begin
			done_enable_ff <= 1'b0;
			done_priority_ff <= 1'b0;
		end else begin
			if (wr_enables) begin
				done_enable_ff <= wbyte[`NAC_BIT_DONE];
			end
			if (wr_priority) begin
				done_priority_ff <= wbyte[`NAC_BIT_DONE];
			end
		end
	end

	// Control register view; bit 5 stays zero
	always_comb begin
		ctrl_view = 8'h00;
		ctrl_view[`NAC_BIT_ARRAY_SEL] = array_select_ff;
		ctrl_view[`NAC_BIT_CFG_SEL] = config_space_select_ff;
		ctrl_view[`NAC_BIT_ROW_WIPE] = row_wipe_ff;
		ctrl_view[`NAC_BIT_ABORTED] = aborted_ff;
		ctrl_view[`NAC_BIT_PERMIT] = store_permit_ff;
		ctrl_view[`NAC_BIT_PROG] = prog_trig_ff;
		ctrl_view[`NAC_BIT_FETCH] = fetch_trig_ff;
	end

	// Read mux; the unlock port and unmapped words read as zero
	always_comb begin
		nxt_rdat = 8'h00;
		case (wb_adr_i)
			`NAC_OFS_CTRL: nxt_rdat = ctrl_view;
			`NAC_OFS_UNLOCK: nxt_rdat = 8'h00;
			`NAC_OFS_ADDR: nxt_rdat = eeprom_address_ff;
			`NAC_OFS_DATA: nxt_rdat = eeprom_data_ff;
			`NAC_OFS_FLAGS: nxt_rdat[`NAC_BIT_DONE] = done_flag_ff;
			`NAC_OFS_ENABLES: nxt_rdat[`NAC_BIT_DONE] = done_enable_ff;
			`NAC_OFS_PRIORITY: nxt_rdat[`NAC_BIT_DONE] = done_priority_ff;
			default: nxt_rdat = 8'h00;
		endcase
	end

	// Ack one cycle after the request, dropped the cycle after
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_ff <= 1'b0;
			rdat_ff <= 32'h00000000;
		end else begin
			ack_ff <= bus_req & ~ack_ff;
			if (bus_req && !ack_ff) begin
				rdat_ff <= {24'h000000, nxt_rdat};
			end
		end
	end

	// Outputs straight from flip-flops
	assign wb_ack_o = ack_ff;
	assign wb_dat_o = rdat_ff;
	assign prog_busy_o = busy_ff;
	assign nvm_done_flag_o = done_flag_ff;
	assign aborted_program_flag_o = aborted_ff;
	assign row_wipe_done_o = wipe_pulse_ff;
endmodule : nac_top

// ### tb/nac_properties.sv
// Checker for nac_top: bus handshake, unlock port, program cycle.
// Assumes it is bound to nac_top and sees only its ports.
`include "nac_defines.svh"
module nac_properties
	import nac_pkg::*;
#(
	parameter logic [`NAC_CNT_W-1:0] PROG_CYCLES = `NAC_CNT_W'(`NAC_PROG_CYCLES),
	parameter logic [`NAC_CNT_W-1:0] PWRT_CYCLES = `NAC_CNT_W'(`NAC_PWRT_CYCLES)
)(
	// Clock and resets
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic por_i,
	// Wishbone
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	// Status
	input wire logic prog_busy_o,
	input wire logic nvm_done_flag_o,
	input wire logic aborted_program_flag_o,
	input wire logic row_wipe_done_o
);
	// Counts busy cycles; either reset restarts it
	logic [`NAC_CNT_W:0] busy_cnt_ff;
	always_ff @(posedge clk_i) begin
		if (rst_i || por_i || !prog_busy_o) begin
			busy_cnt_ff <= '0;
		end else begin
			busy_cnt_ff <= busy_cnt_ff + 1'b1;
		end
	end

	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i || por_i);

	// Steps of a bus request and of a program cycle
	sequence s_new_req;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence s_start;
		$rose(prog_busy_o);
	endsequence
	sequence s_end;
		$fell(prog_busy_o);
	endsequence

	AST_ACK_NEXT: assert property (s_new_req |=> wb_ack_o)
		else $error("ack missing one cycle after request");
	AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	AST_ACK_CAUSE: assert property (wb_ack_o |-> $past(wb_cyc_i) && $past(wb_stb_i))
		else $error("ack without request");
	AST_UNLOCK_ZERO: assert property (wb_ack_o && !wb_we_i
		&& wb_adr_i == `NAC_OFS_UNLOCK |-> wb_dat_o == 32'h0)
		else $error("unlock port read not zero");
	AST_CTRL_BIT5: assert property (wb_ack_o && !wb_we_i
		&& wb_adr_i == `NAC_OFS_CTRL |-> wb_dat_o[5] == 1'b0)
		else $error("control bit 5 read as one");
	AST_START_CAUSE: assert property (s_start |-> $past(wb_ack_o) && $past(wb_we_i)
		&& $past(wb_adr_i) == `NAC_OFS_CTRL && $past(wb_dat_i[1]))
		else $error("program cycle without trigger write");
	AST_START_ABORT: assert property (s_start |-> aborted_program_flag_o)
		else $error("aborted flag not set at start");
	AST_BUSY_LEN: assert property (s_end |-> busy_cnt_ff >= PROG_CYCLES
		&& busy_cnt_ff <= PROG_CYCLES + 1)
		else $error("program cycle length wrong");
	AST_DONE_SET: assert property (s_end |-> nvm_done_flag_o && !aborted_program_flag_o)
		else $error("completion flags wrong");
	AST_DONE_HOLD: assert property (nvm_done_flag_o && !(wb_cyc_i && wb_stb_i && wb_we_i
		&& wb_adr_i == `NAC_OFS_FLAGS) |=> nvm_done_flag_o)
		else $error("done flag cleared without software");
endmodule : nac_properties

// ### tb/tb_top.sv
// Testbench for nac_top: register table, then program, fetch and abort cases.
// Assumes package and header compiled first; checker bound at the foot.
`include "nac_defines.svh"
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	// Short counts keep the run brief
	localparam logic [15:0] PROG_N = 16'h0008;
	localparam logic [15:0] PWRT_N = 16'h0020;
	typedef struct packed {
		logic [7:0] a;
		logic [3:0] s;
		logic [7:0] d;
		logic [7:0] m;
		logic [7:0] e;
	} nac_row_t;
	logic clk_i, rst_i, por_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic [7:0] wb_adr_i;
	logic [3:0] wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o;
	logic prog_busy_o, nvm_done_flag_o, aborted_program_flag_o, row_wipe_done_o;
	logic [7:0] rd;
	logic wiped = 1'b0;
	int n_fail, num_checks, i;
	// Write, read-back mask and expected value per row
	nac_row_t rows [7] = '{
		'{`NAC_OFS_CTRL, 4'hF, 8'h24, 8'h37, 8'h04},
		'{`NAC_OFS_ADDR, 4'hF, 8'h3C, 8'hFF, 8'h3C},
		'{`NAC_OFS_ADDR, 4'h0, 8'hFF, 8'hFF, 8'h3C},
		'{`NAC_OFS_DATA, 4'hF, 8'hA5, 8'hFF, 8'hA5},
		'{`NAC_OFS_UNLOCK, 4'hF, 8'h55, 8'hFF, 8'h00},
		'{8'h1C, 4'hF, 8'hFF, 8'hFF, 8'h00},
		'{`NAC_OFS_ENABLES, 4'hF, 8'h10, 8'h10, 8'h10}};

	nac_top #(.PROG_CYCLES(PROG_N), .PWRT_CYCLES(PWRT_N)) dut (.clk_i, .rst_i, .por_i,
		.wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
		.wb_ack_o, .prog_busy_o, .nvm_done_flag_o, .aborted_program_flag_o,
		.row_wipe_done_o);

	// Clock, 5 ns period
	initial begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end

	// The wipe pulse lasts one cycle, so it is caught here
	always @(posedge clk_i) begin
		if (row_wipe_done_o === 1'b1) begin
			wiped <= 1'b1;
		end
	end

	task automatic test_done;
		if (n_fail == 0 && num_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : test_done

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	// One classic cycle; holds until ack is sampled, then releases
	task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d,
		input logic [3:0] s);
		int k;
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_sel_i <= s;
		wb_dat_i <= {24'h000000, d};
		for (k = 0; k < 20 && wb_ack_o !== 1'b1; k++) @(posedge clk_i);
		if (wb_ack_o !== 1'b1) begin
			n_fail++;
			test_done();
		end
		rd = wb_dat_o[7:0];
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
		#1;
	endtask : wb

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		wb(1'b1, a, d, 4'hF);
	endtask : wr

	task automatic rdc(input string nm, input logic [7:0] a, input logic [7:0] m,
		input logic [7:0] e);
		wb(1'b0, a, 8'h00, 4'hF);
		chk(nm, {24'h0, rd & m}, {24'h0, e});
	endtask : rdc

	// Unlock keys, then the trigger write
	task automatic prog(input logic [7:0] c);
		wr(`NAC_OFS_UNLOCK, `NAC_KEY_FIRST);
		wr(`NAC_OFS_UNLOCK, `NAC_KEY_SECOND);
		wr(`NAC_OFS_CTRL, c);
	endtask : prog

	// Bounded wait for the end of a program cycle
	task automatic wait_idle;
		int k;
		for (k = 0; k < 60 && prog_busy_o !== 1'b0; k++) @(posedge clk_i);
		if (prog_busy_o !== 1'b0) begin
			n_fail++;
			test_done();
		end
		repeat (2) @(posedge clk_i);
		#1;
	endtask : wait_idle

	// Main sequence
	initial begin
		{rst_i, por_i} = 2'b11;
		{wb_cyc_i, wb_stb_i, wb_we_i} = 3'h0;
		wb_adr_i = 8'h00;
		wb_sel_i = 4'hF;
		wb_dat_i = 32'h0;
		n_fail = 0;
		num_checks = 0;
		repeat (5) @(posedge clk_i);
		{rst_i, por_i} <= 2'b00;
		repeat (8) @(posedge clk_i);
		rdc("ctrl reset", `NAC_OFS_CTRL, 8'hFF, 8'h00);
		for (i = 0; i < 7; i++) begin
			wb(1'b1, rows[i].a, rows[i].d, rows[i].s);
			rdc("table", rows[i].a, rows[i].m, rows[i].e);
		end
		// EEPROM byte program, address write blocked meanwhile
		prog(8'h06);
		wr(`NAC_OFS_ADDR, 8'h11);
		chk("busy", prog_busy_o, 1);
		chk("aborted", aborted_program_flag_o, 1);
		wait_idle();
		chk("done", nvm_done_flag_o, 1);
		chk("aborted end", aborted_program_flag_o, 0);
		rdc("addr frozen", `NAC_OFS_ADDR, 8'hFF, 8'h3C);
		rdc("trig clear", `NAC_OFS_CTRL, 8'h03, 8'h00);
		wr(`NAC_OFS_DATA, 8'h00);
		wr(`NAC_OFS_CTRL, 8'h05);
		rdc("fetch", `NAC_OFS_DATA, 8'hFF, 8'hA5);
		wr(`NAC_OFS_DATA, 8'h00);
		wr(`NAC_OFS_CTRL, 8'h85);
		wr(`NAC_OFS_CTRL, 8'h45);
		rdc("fetch gated", `NAC_OFS_DATA, 8'hFF, 8'h00);
		wr(`NAC_OFS_FLAGS, 8'h00);
		chk("done clear", nvm_done_flag_o, 0);
		// Permit and trigger in one write must not start
		wr(`NAC_OFS_CTRL, 8'h00);
		prog(8'h06);
		repeat (3) @(posedge clk_i);
		#1;
		chk("same write", prog_busy_o, 0);
		chk("improper", aborted_program_flag_o, 1);
		// Foreign write between the keys
		wr(`NAC_OFS_CTRL, 8'h04);
		wr(`NAC_OFS_UNLOCK, `NAC_KEY_FIRST);
		wr(`NAC_OFS_ADDR, 8'h3C);
		wr(`NAC_OFS_UNLOCK, `NAC_KEY_SECOND);
		wr(`NAC_OFS_CTRL, 8'h06);
		repeat (3) @(posedge clk_i);
		#1;
		chk("broken keys", prog_busy_o, 0);
		// Flash row erase
		wr(`NAC_OFS_CTRL, 8'h94);
		prog(8'h96);
		wait_idle();
		chk("wipe pulse", wiped, 1);
		rdc("wipe clear", `NAC_OFS_CTRL, 8'h10, 8'h00);
		// Reset in mid-cycle with configuration space selected
		wr(`NAC_OFS_CTRL, 8'h44);
		prog(8'h46);
		chk("config busy", prog_busy_o, 1);
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		#1;
		chk("reset busy", prog_busy_o, 0);
		chk("reset abort", aborted_program_flag_o, 1);
		rdc("select kept", `NAC_OFS_CTRL, 8'hC0, 8'h40);
		// Power-on again: permit cleared, and a start is refused while the hold runs
		@(posedge clk_i);
		{rst_i, por_i} <= 2'b11;
		repeat (2) @(posedge clk_i);
		{rst_i, por_i} <= 2'b00;
		rdc("permit por", `NAC_OFS_CTRL, 8'h04, 8'h00);
		wr(`NAC_OFS_CTRL, 8'h04);
		prog(8'h06);
		repeat (3) @(posedge clk_i);
		#1;
		chk("hold busy", prog_busy_o, 0);
		chk("hold abort", aborted_program_flag_o, 1);
		repeat (40) @(posedge clk_i);
		prog(8'h06);
		chk("after hold", prog_busy_o, 1);
		wait_idle();
		chk("hold done", nvm_done_flag_o, 1);
		test_done();
	end
endmodule : tb_top

bind nac_top nac_properties #(.PROG_CYCLES(PROG_CYCLES), .PWRT_CYCLES(PWRT_CYCLES)) u_props (
	.clk_i, .rst_i, .por_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
	.wb_dat_i, .wb_dat_o, .wb_ack_o, .prog_busy_o, .nvm_done_flag_o,
	.aborted_program_flag_o, .row_wipe_done_o);
